//--- include/pmbc_pkg.sv
// Package with constants and types of the power mode and brown-out control
package pmbc_pkg;
	localparam int SYS_CLK_MHZ = 200;
	localparam int WAKE_TIMER_CYCLES = 1024;
	localparam int RESET_PULSE_CYCLES = 4;
	localparam int IDLE_RAM_BLOCK_CYCLES = 2;
	localparam int MIN_REENTRY_NS = 4000;
	localparam int MIN_REENTRY_CYCLES =
		(MIN_REENTRY_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [2:0] CLK_DIV_NORMAL = 3'h0;
	localparam logic [1:0] OSC_SEL_LOW_POWER_RC = 2'h2;
	localparam logic [1:0] SEL_LEVEL_RESET = 2'h0;
	localparam int NUM_EXT_IRQ = 4;
	localparam logic [3:0] EXT_IRQ_RESET = 4'h0;
	localparam logic [3:0] EXT_MODE_RESET = 4'h0;

	typedef enum logic [2:0] {
		PMBC_NORMAL,
		PMBC_IDLE,
		PMBC_POWERDOWN,
		PMBC_WAKE_TIMING,
		PMBC_RESET_HOLD
	} pmbc_state_t;
endpackage

//--- rtl/pmbc_sync.sv
// Two-flop synchroniser, one per bit
`timescale 1ns/1ps
module pmbc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stage_one <= '0;
			sync_out  <= '0;
		end else begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end
endmodule // pmbc_sync

//--- rtl/pmbc_wake_timer.sv
// Wake-up timer that counts to full after oscillator restart
`timescale 1ns/1ps
module pmbc_wake_timer #(
	parameter int COUNT = pmbc_pkg::WAKE_TIMER_CYCLES
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Control
	input  wire logic start,
	output logic      full
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	logic [CW-1:0] count;
	logic          running;
	logic [CW-1:0] next_count;
	logic          next_running;
	logic          next_full;

	always_comb begin
		next_count   = count;
		next_running = running;
		next_full    = 1'b0;
		if (start) begin
			next_count   = '0;
			next_running = 1'b1;
		end else if (running) begin
			if (count == LAST) begin
				next_running = 1'b0;
				next_full    = 1'b1;
			end else begin
				next_count = count + CW'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count   <= '0;
			running <= 1'b0;
			full    <= 1'b0;
		end else begin
			count   <= next_count;
			running <= next_running;
			full    <= next_full;
		end
	end
endmodule // pmbc_wake_timer

//--- rtl/pmbc_power_control.sv
// Power mode sequencer with brown-out monitor flags and wake control
`timescale 1ns/1ps
// Overview of operation
// - Fixed monitor plus selectable monitor with a two-bit level choice.
// - Fixed trip sets its flag; both enables raise interrupt in normal/idle.
// - Selectable monitor same; its interrupt also wakes power-down if kept.
// - Fixed trip with reset enable resets system and sets flag.
// - Selectable reset likewise; in power-down only when monitor is kept.
// - Non-zero divider field lowers CPU speed; zero keeps normal speed.
// - Source select may pick low-power RC; divided gives slowest clock.
// - Non-stop watchdog overflow in power-down sets flag and wakes.
// - Kept monitor trip in power-down sets flag and wakes.
// - Idle request stops CPU clock, state and ports kept.
// - Peripherals keep running in idle; counter array, watchdog if set.
// - Enabled interrupt or reset ends idle; handler runs at once.
// - Power-down request stops oscillator and flash; RAM retained.
// - Power-down ends only on the listed wake sources.
// - In power-down, edge triggers act as matching level triggers.
// - Interrupt wake restarts oscillator, counts timer, then frees clock.
// - Reset-pin rise wakes; timer runs; execution starts at reset low.
// - Reset ending idle blocks RAM access for two cycles, not ports.
// - Enabled keypad match wakes like an interrupt, then its handler.
// - Device clears idle and power-down requests on mode exit.
// - Flags clear only by writing one; zero has no effect.
module pmbc_power_control #(
	parameter int WAKE_COUNT  = pmbc_pkg::WAKE_TIMER_CYCLES,
	parameter int NUM_EXT_IRQ = pmbc_pkg::NUM_EXT_IRQ
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	// Detector trips from analogue comparators (asynchronous)
	input  wire logic                   fixed_monitor_trip,
	input  wire logic                   selectable_monitor_trip,
	// Configuration from the CPU
	input  wire logic [1:0]             selectable_level_select,
	input  wire logic                   selectable_monitor_enable,
	input  wire logic                   system_flag_irq_enable,
	input  wire logic                   fixed_monitor_irq_enable,
	input  wire logic                   selectable_monitor_irq_enable,
	input  wire logic                   keep_monitor_in_powerdown,
	input  wire logic                   fixed_monitor_reset_enable,
	input  wire logic                   selectable_monitor_reset_enable,
	input  wire logic [2:0]             system_clock_divider_select,
	input  wire logic [1:0]             oscillator_source_select,
	input  wire logic                   nonstop_watchdog_enable,
	input  wire logic                   watchdog_enable,
	input  wire logic                   watchdog_reset_enable,
	input  wire logic                   counter_array_idle_run,
	input  wire logic                   watchdog_idle_run,
	// Mode requests and flag clears (one-cycle pulses)
	input  wire logic                   idle_request_set,
	input  wire logic                   idle_request_clear,
	input  wire logic                   powerdown_request_set,
	input  wire logic                   powerdown_request_clear,
	input  wire logic                   fixed_flag_clear,
	input  wire logic                   selectable_flag_clear,
	input  wire logic                   watchdog_flag_clear,
	input  wire logic                   ext_reset_flag_clear,
	// Wake sources
	input  wire logic                   watchdog_overflow,
	input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_pin_n,
	input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_enable,
	input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_edge_mode,
	input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_active_high,
	input  wire logic                   keypad_match,
	input  wire logic                   keypad_irq_enable,
	input  wire logic                   usb_wake,
	input  wire logic                   usb_wake_enable,
	input  wire logic                   reset_pin,
	input  wire logic                   cpu_irq_pending,
	// Mode and status outputs
	output logic                        idle_request_bit,
	output logic                        powerdown_request_bit,
	output logic                        fixed_monitor_flag,
	output logic                        selectable_monitor_flag,
	output logic                        watchdog_overflow_flag,
	output logic                        ext_reset_flag,
	output logic                        system_flag_irq,
	output logic                        system_reset,
	output logic                        cpu_clock_enable,
	output logic                        oscillator_enable,
	output logic                        flash_power_enable,
	output logic                        ram_access_block,
	output logic                        slow_mode_active,
	output logic                        sub_clock_active,
	output logic                        peripheral_run,
	output logic                        counter_array_run,
	output logic                        watchdog_run,
	output logic                        selectable_monitor_active,
	output logic [1:0]                  selectable_level,
	output logic                        wake_irq_pending,
	output logic                        reentry_ok
);
	localparam int RC = pmbc_pkg::RESET_PULSE_CYCLES;
	localparam int MR = pmbc_pkg::MIN_REENTRY_CYCLES;
	localparam int BR = pmbc_pkg::IDLE_RAM_BLOCK_CYCLES;

	// Synchronised pin inputs
	logic                   fixed_trip_s;
	logic                   sel_trip_s;
	logic                   reset_pin_s;
	logic [NUM_EXT_IRQ-1:0] ext_pin_s;
	logic                   keypad_s;
	logic                   usb_s;

	pmbc_sync #(.WIDTH(NUM_EXT_IRQ + 5)) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({fixed_monitor_trip, selectable_monitor_trip, reset_pin,
		            ext_irq_pin_n, keypad_match, usb_wake}),
		.sync_out ({fixed_trip_s, sel_trip_s, reset_pin_s, ext_pin_s,
		            keypad_s, usb_s})
	);

	// State
	pmbc_pkg::pmbc_state_t state;
	pmbc_pkg::pmbc_state_t next_state;
	logic       reset_pin_d;
	logic       fixed_trip_d;
	logic       sel_trip_d;
	logic       wake_by_reset;
	logic       next_wake_by_reset;
	logic [7:0] hold_count;
	logic [7:0] next_hold_count;
	logic [15:0] reentry_count;
	logic [15:0] next_reentry_count;
	logic [1:0] ram_block_count;
	logic [1:0] next_ram_block_count;
	logic       next_idle_req;
	logic       next_pd_req;
	logic       next_fixed_flag;
	logic       next_sel_flag;
	logic       next_wdt_flag;
	logic       next_ext_flag;
	logic       next_wake_irq;
	logic       timer_start;
	logic       timer_full;

	pmbc_wake_timer #(.COUNT(WAKE_COUNT)) u_wake_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.start   (timer_start),
		.full    (timer_full)
	);

	// Event decode
	logic                   fixed_event;
	logic                   sel_event;
	logic                   reset_rise;
	logic                   in_pd;
	logic [NUM_EXT_IRQ-1:0] ext_level_hit;
	logic                   ext_wake;
	logic                   sel_wake;
	logic                   wdt_wake;
	logic                   irq_wake;
	logic                   fixed_irq;
	logic                   sel_irq;
	logic                   fixed_reset;
	logic                   sel_reset;
	logic                   wdt_reset;

	assign in_pd = (state == pmbc_pkg::PMBC_POWERDOWN);
	assign fixed_event = fixed_trip_s & ~fixed_trip_d & ~in_pd;
	assign sel_event = sel_trip_s & ~sel_trip_d & selectable_monitor_enable
		& (~in_pd | keep_monitor_in_powerdown);
	assign reset_rise = reset_pin_s & ~reset_pin_d;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT_IRQ; gi++) begin : g_ext
			// Edge trigger taken as level while powered down
			assign ext_level_hit[gi] = ext_irq_enable[gi] & (ext_irq_active_high[gi]
				? ext_pin_s[gi] : ~ext_pin_s[gi]);
		end
	endgenerate

	assign ext_wake = |ext_level_hit;
	assign fixed_irq = fixed_monitor_flag & system_flag_irq_enable
		& fixed_monitor_irq_enable;
	assign sel_irq = selectable_monitor_flag & system_flag_irq_enable
		& selectable_monitor_irq_enable;
	assign sel_wake = sel_event & keep_monitor_in_powerdown
		& ((system_flag_irq_enable & selectable_monitor_irq_enable)
		| selectable_monitor_reset_enable);
	assign wdt_wake = watchdog_overflow & watchdog_enable
		& nonstop_watchdog_enable;
	assign irq_wake = ext_wake | (keypad_s & keypad_irq_enable)
		| (usb_s & usb_wake_enable) | sel_wake | wdt_wake;
	assign fixed_reset = fixed_event & fixed_monitor_reset_enable;
	assign sel_reset = sel_event & selectable_monitor_reset_enable;
	assign wdt_reset = watchdog_overflow & watchdog_enable
		& watchdog_reset_enable & (~in_pd | nonstop_watchdog_enable);

	// Flags: set wins over clear, write-one clear only
	always_comb begin
		next_fixed_flag = fixed_event
			| (fixed_monitor_flag & ~fixed_flag_clear);
		next_sel_flag = sel_event
			| (selectable_monitor_flag & ~selectable_flag_clear);
		next_wdt_flag = (watchdog_overflow & watchdog_enable
			& (~in_pd | nonstop_watchdog_enable))
			| (watchdog_overflow_flag & ~watchdog_flag_clear);
		next_ext_flag = reset_rise
			| (ext_reset_flag & ~ext_reset_flag_clear);
	end

	// Mode sequencer
	always_comb begin
		next_state           = state;
		next_wake_by_reset   = wake_by_reset;
		next_hold_count      = hold_count;
		next_idle_req        = idle_request_bit;
		next_pd_req          = powerdown_request_bit;
		next_wake_irq        = wake_irq_pending & ~cpu_irq_pending;
		next_ram_block_count = (ram_block_count != 2'h0)
			? ram_block_count - 2'h1 : 2'h0;
		next_reentry_count   = (reentry_count != 16'h0)
			? reentry_count - 16'h1 : 16'h0;
		timer_start          = 1'b0;
		unique case (state)
			pmbc_pkg::PMBC_NORMAL: begin
				if (idle_request_clear)
					next_idle_req = 1'b0;
				if (powerdown_request_clear)
					next_pd_req = 1'b0;
				if (powerdown_request_set) begin
					next_pd_req = 1'b1;
					next_state  = pmbc_pkg::PMBC_POWERDOWN;
				end else if (idle_request_set) begin
					next_idle_req = 1'b1;
					next_state    = pmbc_pkg::PMBC_IDLE;
				end
			end
			pmbc_pkg::PMBC_IDLE: begin
				if (reset_rise | fixed_reset | sel_reset | wdt_reset) begin
					next_idle_req        = 1'b0;
					next_ram_block_count = 2'(BR);
					next_hold_count      = 8'(RC);
					next_state           = pmbc_pkg::PMBC_RESET_HOLD;
				end else if (cpu_irq_pending | fixed_irq | sel_irq) begin
					next_idle_req = 1'b0;
					next_state    = pmbc_pkg::PMBC_NORMAL;
				end
			end
			pmbc_pkg::PMBC_POWERDOWN: begin
				if (reset_rise | (sel_event & selectable_monitor_reset_enable)
					| wdt_reset) begin
					next_wake_by_reset = 1'b1;
					timer_start        = 1'b1;
					next_pd_req        = 1'b0;
					next_state         = pmbc_pkg::PMBC_WAKE_TIMING;
				end else if (irq_wake) begin
					next_wake_by_reset = 1'b0;
					timer_start        = 1'b1;
					next_pd_req        = 1'b0;
					next_state         = pmbc_pkg::PMBC_WAKE_TIMING;
				end
			end
			pmbc_pkg::PMBC_WAKE_TIMING: begin
				if (timer_full) begin
					next_reentry_count = 16'(MR);
					if (wake_by_reset) begin
						next_hold_count = 8'(RC);
						next_state      = pmbc_pkg::PMBC_RESET_HOLD;
					end else begin
						next_wake_irq = 1'b1;
						next_state    = pmbc_pkg::PMBC_NORMAL;
					end
				end
			end
			pmbc_pkg::PMBC_RESET_HOLD: begin
				if (hold_count != 8'h0)
					next_hold_count = hold_count - 8'h1;
				else if (~reset_pin_s) begin
					next_reentry_count = 16'(MR);
					next_state         = pmbc_pkg::PMBC_NORMAL;
				end
			end
		endcase
		if (state != pmbc_pkg::PMBC_RESET_HOLD && state != pmbc_pkg::PMBC_IDLE
			&& (fixed_reset | ((state == pmbc_pkg::PMBC_NORMAL)
			& (sel_reset | wdt_reset | reset_rise)))) begin
			next_hold_count = 8'(RC);
			next_idle_req   = 1'b0;
			next_pd_req     = 1'b0;
			next_state      = pmbc_pkg::PMBC_RESET_HOLD;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state                   <= pmbc_pkg::PMBC_NORMAL;
			reset_pin_d             <= 1'b0;
			fixed_trip_d            <= 1'b0;
			sel_trip_d              <= 1'b0;
			wake_by_reset           <= 1'b0;
			hold_count              <= 8'h0;
			reentry_count           <= 16'(MR);
			ram_block_count         <= 2'h0;
			idle_request_bit        <= 1'b0;
			powerdown_request_bit   <= 1'b0;
			fixed_monitor_flag      <= 1'b0;
			selectable_monitor_flag <= 1'b0;
			watchdog_overflow_flag  <= 1'b0;
			ext_reset_flag          <= 1'b0;
			wake_irq_pending        <= 1'b0;
		end else begin
			state                   <= next_state;
			reset_pin_d             <= reset_pin_s;
			fixed_trip_d            <= fixed_trip_s;
			sel_trip_d              <= sel_trip_s;
			wake_by_reset           <= next_wake_by_reset;
			hold_count              <= next_hold_count;
			reentry_count           <= next_reentry_count;
			ram_block_count         <= next_ram_block_count;
			idle_request_bit        <= next_idle_req;
			powerdown_request_bit   <= next_pd_req;
			fixed_monitor_flag      <= next_fixed_flag;
			selectable_monitor_flag <= next_sel_flag;
			watchdog_overflow_flag  <= next_wdt_flag;
			ext_reset_flag          <= next_ext_flag;
			wake_irq_pending        <= next_wake_irq;
		end
	end

	// Mode outputs
	assign system_flag_irq = (fixed_irq | sel_irq)
		& (state == pmbc_pkg::PMBC_NORMAL | state == pmbc_pkg::PMBC_IDLE
		| (in_pd & keep_monitor_in_powerdown));
	assign system_reset = (state == pmbc_pkg::PMBC_RESET_HOLD);
	assign cpu_clock_enable = (state == pmbc_pkg::PMBC_NORMAL);
	assign oscillator_enable = ~in_pd;
	assign flash_power_enable = ~in_pd;
	assign ram_access_block = (ram_block_count != 2'h0);
	assign slow_mode_active =
		(system_clock_divider_select != pmbc_pkg::CLK_DIV_NORMAL);
	assign sub_clock_active =
		(oscillator_source_select == pmbc_pkg::OSC_SEL_LOW_POWER_RC);
	assign peripheral_run = ~in_pd & (state != pmbc_pkg::PMBC_WAKE_TIMING);
	assign counter_array_run = cpu_clock_enable
		| ((state == pmbc_pkg::PMBC_IDLE) & counter_array_idle_run);
	assign watchdog_run = watchdog_enable & (cpu_clock_enable
		| ((state == pmbc_pkg::PMBC_IDLE) & watchdog_idle_run)
		| (in_pd & nonstop_watchdog_enable));
	assign selectable_monitor_active = selectable_monitor_enable
		& (~in_pd | keep_monitor_in_powerdown);
	assign selectable_level = selectable_level_select;
	assign reentry_ok = (reentry_count == 16'h0);
endmodule // pmbc_power_control

//--- bench/pmbc_power_control_asserts.sv
// Checker of the power control block's port behaviour
`timescale 1ns/1ps
module pmbc_power_control_asserts #(
	parameter int WAKE_COUNT = 16
) (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	// Configuration
	input wire logic [1:0] selectable_level_select,
	input wire logic [2:0] system_clock_divider_select,
	input wire logic [1:0] oscillator_source_select,
	input wire logic       system_flag_irq_enable,
	input wire logic       fixed_monitor_irq_enable,
	input wire logic       fixed_flag_clear,
	// Status
	input wire logic       idle_request_bit,
	input wire logic       powerdown_request_bit,
	input wire logic       fixed_monitor_flag,
	input wire logic       system_flag_irq,
	input wire logic       system_reset,
	input wire logic       cpu_clock_enable,
	input wire logic       oscillator_enable,
	input wire logic       flash_power_enable,
	input wire logic       ram_access_block,
	input wire logic       slow_mode_active,
	input wire logic       sub_clock_active,
	input wire logic       peripheral_run,
	input wire logic [1:0] selectable_level
);
	localparam int WAKE_MAX = 100;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence s_wake_start;
		$fell(powerdown_request_bit) && !$past(rst);
	endsequence
	sequence s_clock_held;
		!cpu_clock_enable [*8];
	endsequence
	a_wake_held:
		assert property (s_wake_start |-> s_clock_held)
		else $error("CPU clock released too early after wake");
	a_wake_bounded:
		assert property (s_wake_start |->
			##[1:WAKE_MAX] (cpu_clock_enable || system_reset))
		else $error("Wake sequence did not finish");
	a_pd_power_off:
		assert property (powerdown_request_bit |-> !cpu_clock_enable &&
			!oscillator_enable && !flash_power_enable)
		else $error("Clock, oscillator or flash on in power-down");
	a_idle_clock_stop:
		assert property (idle_request_bit |-> !cpu_clock_enable &&
			oscillator_enable && peripheral_run)
		else $error("Idle clocking wrong");
	a_flag_holds:
		assert property (fixed_monitor_flag && !fixed_flag_clear |=>
			fixed_monitor_flag)
		else $error("Fixed flag cleared without a clear");
	a_flag_irq:
		assert property (fixed_monitor_flag && system_flag_irq_enable &&
			fixed_monitor_irq_enable && cpu_clock_enable |-> system_flag_irq)
		else $error("System flag interrupt missing");
	a_reset_pulse:
		assert property ($rose(system_reset) |-> system_reset [*4])
		else $error("System reset too short");
	a_ram_block:
		assert property ($rose(ram_access_block) |->
			ram_access_block [*2] ##1 !ram_access_block)
		else $error("RAM block not two cycles");
	a_level_mirror:
		assert property (selectable_level == selectable_level_select)
		else $error("Monitor level not as selected");
	a_slow_mode:
		assert property (slow_mode_active ==
			(system_clock_divider_select != pmbc_pkg::CLK_DIV_NORMAL))
		else $error("Slow mode wrong");
	a_sub_clock:
		assert property (sub_clock_active ==
			(oscillator_source_select == pmbc_pkg::OSC_SEL_LOW_POWER_RC))
		else $error("Sub-clock mode wrong");
endmodule // pmbc_power_control_asserts
bind pmbc_power_control pmbc_power_control_asserts #(
	.WAKE_COUNT(WAKE_COUNT)) i_pmbc_power_control_asserts (.*);

//--- bench/pmbc_wake_source.sv
// Wake-source model: one external interrupt pin and the reset pin
`timescale 1ns/1ps
module pmbc_wake_source #(
	parameter int RESET_HOLD = 48
) (
	// Clock and commands
	input  wire logic sys_clk,
	input  wire logic go_irq,
	input  wire logic go_rst,
	// Device status
	input  wire logic cpu_clock_enable,
	// Pins
	output logic      irq_pin_n,
	output logic      reset_pin
);
	int hold = 0;
	initial irq_pin_n = 1'b1;
	initial reset_pin = 1'b0;
	always @(posedge sys_clk) begin
		if (go_irq)
			irq_pin_n <= 1'b0;
		else if (cpu_clock_enable)
			irq_pin_n <= 1'b1; // Low until running, then pulled up
		if (go_rst) begin
			reset_pin <= 1'b1;
			hold <= RESET_HOLD; // Held past the wake timeout
		end else if (hold > 0) begin
			hold <= hold - 1;
			reset_pin <= (hold > 1);
		end
	end
endmodule // pmbc_wake_source

//--- bench/testbench.sv
// Self-checking bench of the power mode and brown-out control
`timescale 1ns/1ps
module testbench;
	localparam int WAKE_CNT = 16;
	int errors = 0;
	int checks_done = 0;
	logic sys_clk = 1'b0, rst = 1'b1, go_irq = 1'b0, go_rst = 1'b0;
	logic fixed_monitor_trip = 1'b0, selectable_monitor_trip = 1'b0;
	logic [1:0] selectable_level_select = 2'h0, oscillator_source_select = 2'h0;
	logic [2:0] system_clock_divider_select = 3'h0;
	logic system_flag_irq_enable = 1'b1, fixed_monitor_irq_enable = 1'b1;
	logic selectable_monitor_enable = 1'b1, keep_monitor_in_powerdown = 1'b1;
	logic selectable_monitor_irq_enable = 1'b1, watchdog_enable = 1'b1;
	logic fixed_monitor_reset_enable = 1'b0, watchdog_reset_enable = 1'b0;
	logic selectable_monitor_reset_enable = 1'b0, usb_wake_enable = 1'b1;
	logic nonstop_watchdog_enable = 1'b1, counter_array_idle_run = 1'b0;
	logic watchdog_idle_run = 1'b0, idle_request_set = 1'b0;
	logic idle_request_clear = 1'b0, powerdown_request_set = 1'b0;
	logic powerdown_request_clear = 1'b0, fixed_flag_clear = 1'b0;
	logic selectable_flag_clear = 1'b0, watchdog_flag_clear = 1'b0;
	logic ext_reset_flag_clear = 1'b0, watchdog_overflow = 1'b0;
	logic keypad_match = 1'b0, keypad_irq_enable = 1'b1, usb_wake = 1'b0;
	logic cpu_irq_pending = 1'b0, irq_pin_n, reset_pin;
	logic [3:0] ext_irq_enable = 4'h1, ext_irq_edge_mode = 4'h1;
	logic [3:0] ext_irq_active_high = 4'h0, ext_irq_pin_n;
	logic idle_request_bit, powerdown_request_bit, fixed_monitor_flag;
	logic selectable_monitor_flag, watchdog_overflow_flag, ext_reset_flag;
	logic system_flag_irq, system_reset, cpu_clock_enable, oscillator_enable;
	logic flash_power_enable, ram_access_block, slow_mode_active, reentry_ok;
	logic sub_clock_active, peripheral_run, counter_array_run, watchdog_run;
	logic selectable_monitor_active, wake_irq_pending;
	logic [1:0] selectable_level;
	assign ext_irq_pin_n = {3'h7, irq_pin_n};
	always #2.5 sys_clk = ~sys_clk;
	pmbc_power_control #(.WAKE_COUNT(WAKE_CNT)) i_pmbc_power_control (.*);
	pmbc_wake_source #(.RESET_HOLD(3 * WAKE_CNT)) i_pmbc_wake_source (
		.sys_clk, .go_irq, .go_rst, .cpu_clock_enable, .irq_pin_n, .reset_pin);
	task automatic check(input logic ok, input string what);
		checks_done++;
		if (ok !== 1'b1) begin
			errors++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wait_run(output int n);
		for (n = 0; cpu_clock_enable !== 1'b1; n++) begin
			tick(1);
			if (n > 3000) begin
				errors++;
				conclude();
			end
		end
	endtask
	task automatic t_config();
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			system_clock_divider_select <= 3'(i);
			oscillator_source_select <= 2'(i);
			selectable_level_select <= 2'(3 - i);
			tick(1);
			check(slow_mode_active === (i != 0), "slow");
			check(sub_clock_active === (i % 4 == 2), "sub");
			check(selectable_level === 2'(3 - i), "level");
		end
		@(posedge sys_clk);
		system_clock_divider_select <= 3'h0;
		oscillator_source_select <= 2'h0;
		$display("Test config done");
	endtask
	task automatic t_fixed();
		int n;
		@(posedge sys_clk);
		fixed_monitor_trip <= 1'b1;
		tick(6);
		check(fixed_monitor_flag === 1'b1, "flag set");
		check(system_flag_irq === 1'b1, "flag irq");
		@(posedge sys_clk);
		fixed_monitor_trip <= 1'b0;
		tick(6);
		check(fixed_monitor_flag === 1'b1, "flag kept");
		@(posedge sys_clk);
		fixed_flag_clear <= 1'b1;
		fixed_monitor_reset_enable <= 1'b1;
		@(posedge sys_clk);
		fixed_flag_clear <= 1'b0;
		fixed_monitor_trip <= 1'b1;
		tick(1);
		check(fixed_monitor_flag === 1'b0, "flag clear");
		for (n = 0; n < 10 && system_reset !== 1'b1; n++)
			tick(1);
		check(system_reset === 1'b1, "monitor reset");
		@(posedge sys_clk);
		fixed_monitor_trip <= 1'b0;
		fixed_monitor_reset_enable <= 1'b0;
		wait_run(n);
		check(fixed_monitor_flag === 1'b1, "reset flag");
		@(posedge sys_clk);
		fixed_flag_clear <= 1'b1;
		@(posedge sys_clk);
		fixed_flag_clear <= 1'b0;
		$display("Test fixed monitor done");
	endtask
	task automatic t_idle();
		int n;
		for (int r = 0; r < 2; r++) begin
			@(posedge sys_clk);
			counter_array_idle_run <= 1'b1;
			idle_request_set <= 1'b1;
			@(posedge sys_clk);
			idle_request_set <= 1'b0;
			tick(2);
			check(idle_request_bit === 1'b1, "idle");
			check(counter_array_run === 1'b1, "array run");
			@(posedge sys_clk);
			cpu_irq_pending <= (r == 0);
			go_rst <= (r == 1);
			@(posedge sys_clk);
			go_rst <= 1'b0;
			for (n = 0; n < 20 && r == 1 && ram_access_block !== 1'b1; n++)
				tick(1);
			check(r == 0 || ram_access_block === 1'b1, "ram block");
			wait_run(n);
			check(idle_request_bit === 1'b0, "idle exit");
			cpu_irq_pending <= 1'b0;
		end
		@(posedge sys_clk);
		ext_reset_flag_clear <= 1'b1;
		@(posedge sys_clk);
		ext_reset_flag_clear <= 1'b0;
		$display("Test idle done");
	endtask
	task automatic enter_pd();
		int n;
		for (n = 0; n < 1000 && reentry_ok !== 1'b1; n++)
			tick(1);
		check(reentry_ok === 1'b1, "reentry");
		@(posedge sys_clk);
		powerdown_request_set <= 1'b1;
		@(posedge sys_clk);
		powerdown_request_set <= 1'b0;
		tick(2);
		check(powerdown_request_bit === 1'b1, "pd entry");
	endtask
	task automatic t_pd(input int kind);
		int n;
		enter_pd();
		@(posedge sys_clk);
		go_irq <= (kind == 0);
		keypad_match <= (kind == 1);
		watchdog_overflow <= (kind == 2);
		selectable_monitor_trip <= (kind == 3);
		usb_wake <= (kind == 4);
		@(posedge sys_clk);
		go_irq <= 1'b0;
		watchdog_overflow <= 1'b0;
		wait_run(n);
		check(n >= WAKE_CNT && n <= WAKE_CNT + 8, "wake time");
		check(wake_irq_pending === 1'b1, "wake irq");
		check(watchdog_overflow_flag === (kind == 2), "wd flag");
		check(selectable_monitor_flag === (kind == 3), "sel flag");
		@(posedge sys_clk);
		cpu_irq_pending <= 1'b1;
		{keypad_match, selectable_monitor_trip, usb_wake} <= 3'h0;
		{watchdog_flag_clear, selectable_flag_clear} <= 2'h3;
		@(posedge sys_clk);
		cpu_irq_pending <= 1'b0;
		{watchdog_flag_clear, selectable_flag_clear} <= 2'h0;
		$display("Test power-down wake %0d done", kind);
	endtask
	task automatic t_pd_reset();
		int n;
		ext_irq_enable <= 4'h0;
		enter_pd();
		@(posedge sys_clk);
		go_irq <= 1'b1;
		@(posedge sys_clk);
		go_irq <= 1'b0;
		tick(40);
		check(powerdown_request_bit === 1'b1, "no wake");
		@(posedge sys_clk);
		go_rst <= 1'b1;
		@(posedge sys_clk);
		go_rst <= 1'b0;
		for (n = 0; n < 200 && system_reset !== 1'b1; n++)
			tick(1);
		check(n >= WAKE_CNT && ext_reset_flag === 1'b1, "pin wake");
		wait_run(n);
		check(reset_pin === 1'b0, "run at pin low");
		ext_irq_enable <= 4'h1;
		ext_reset_flag_clear <= 1'b1;
		@(posedge sys_clk);
		ext_reset_flag_clear <= 1'b0;
		$display("Test reset wake done");
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_config();
		t_fixed();
		t_idle();
		for (int k = 0; k < 5; k++)
			t_pd(k);
		t_pd_reset();
		conclude();
	end
endmodule // testbench
